// ### oscillator_status_tuning_control_tb.sv
// self-checking bench for the status, output gating, apply and offset logic
// assumes ost_core and the ost_host model; acceptance delay shortened for run time
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin errors++; $display("CHECK FAILED t=%0t %s", $time, msg); end end
module oscillator_status_tuning_control_tb;
	import ost_pkg::*;
	logic mclk = 1'b0; // 40 MHz
	logic nrst = 1'b0; // sync reset, active low
	ost_wr_s reg_wr;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic [31:0] center_freq;
	logic [7:0] drv_kind;
	logic driver_pwr;
	logic clkp_oe;
	logic clkm_oe;
	logic addr_autoinc_off;
	logic signed [31:0] freq_offset;
	logic offset_upd;
	logic oe_drop = 1'b0; // sticky: output enable seen low
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	always #12.5 mclk = ~mclk;
	ost_core #(.ACCEPT_LAT(20), .BOOT_ACTIVE(1'b1)) uut (.mclk(mclk), .nrst(nrst), .reg_wr(reg_wr),
		.rd_addr(rd_addr), .rd_data(rd_data), .center_freq(center_freq), .drv_kind(drv_kind),
		.driver_pwr(driver_pwr), .clkp_oe(clkp_oe), .clkm_oe(clkm_oe),
		.addr_autoinc_off(addr_autoinc_off), .freq_offset(freq_offset), .offset_upd(offset_upd));
	ost_host host (.mclk(mclk), .reg_wr(reg_wr), .rd_addr(rd_addr), .rd_data(rd_data));
	// verdict and end of run
	task automatic wrap_up();
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// hang guard, generous against the roughly 2000 cycles the tests need
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errors++;
			$display("CHECK FAILED t=%0t run too long", $time);
			wrap_up();
		end
	end
	// catches any single low cycle of the enable, even between reads
	always @(posedge mclk) if (clkp_oe !== 1'b1 || clkm_oe !== 1'b1) oe_drop <= 1'b1;
	// read until the masked value matches, bounded
	task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string what);
		logic [7:0] d;
		int k;
		d = 8'h00;
		for (k = 0; k < 300; k++) begin
			host.rd(a, d);
			if ((d & m) === e) break;
		end
		`CHK(d & m, e, what)
	endtask : poll
	// start up reads zero, then active; status is not writable
	task automatic t_boot();
		logic [7:0] d;
		host.rd(ADDR_STAT, d);
		`CHK(d, 8'h00, "start up status")
		poll(ADDR_STAT, 8'h7F, 8'h02, "boot to active");
		`CHK(driver_pwr, 1'b1, "driver on when active")
		host.wr(ADDR_STAT, 8'hFF);
		poll(ADDR_STAT, 8'h7F, 8'h02, "status read only");
	endtask : t_boot
	// each enable control alone turns both outputs off
	task automatic t_oe();
		logic [7:0] tu [4] = '{8'h03, 8'h00, 8'h02, 8'h02};
		logic [7:0] to [4] = '{8'h01, 8'h01, 8'h00, 8'h01};
		for (int i = 0; i < 4; i++) begin
			host.wr(ADDR_UDRV, tu[i]);
			host.wr(ADDR_ODIV, to[i]);
			repeat (4) @(posedge mclk);
			#1 `CHK(clkp_oe, i == 3, "true output enable")
			`CHK(clkm_oe, i == 3, "complement output enable")
		end
	endtask : t_oe
	// standby and back, with both transition codes
	task automatic t_state();
		logic [7:0] d;
		host.wr(ADDR_CMD, CMD_READY);
		host.rd(ADDR_CMD, d);
		`CHK(d, CMD_READY, "command pending")
		poll(ADDR_STAT, 8'h7F, 8'h12, "active to standby");
		poll(ADDR_STAT, 8'h7F, 8'h01, "standby");
		`CHK(driver_pwr, 1'b0, "driver off in standby")
		host.wr(ADDR_CMD, CMD_ACTIVE);
		poll(ADDR_STAT, 8'h7F, 8'h11, "standby to active");
		poll(ADDR_STAT, 8'h7F, 8'h02, "active again");
		`CHK(driver_pwr, 1'b1, "driver back on")
	endtask : t_state
	// one apply variant with a new frequency
	task automatic t_apply(input logic [7:0] cmd, input logic [31:0] f);
		logic [31:0] off0;
		off0 = freq_offset;
		for (int i = 0; i < 4; i++) host.wr(ADDR_FREQ0 + 8'(i), f[31-8*i -: 8]);
		oe_drop = 1'b0;
		host.wr(ADDR_CMD, cmd);
		poll(ADDR_STAT, 8'h86, 8'h86, "busy and tuning");
		`CHK(center_freq, f, "center frequency, msb first")
		poll(ADDR_STAT, 8'hFF, 8'h02, "tuning done, busy clear");
		repeat (3) @(posedge mclk);
		#1 `CHK(oe_drop, ~cmd[1], "output held or kept")
		`CHK(clkp_oe, 1'b1, "output back")
		`CHK(freq_offset, off0, "offset untouched")
	endtask : t_apply
	// forced apply with driver kind zero, then restore
	task automatic t_kind0();
		host.wr(ADDR_KIND, 8'h00);
		host.wr(ADDR_CMD, CMD_APPLY | 8'h01);
		// wait for acceptance first: the old steady code would pass the done poll at once
		poll(ADDR_STAT, 8'h80, 8'h80, "kind zero apply busy");
		poll(ADDR_STAT, 8'hFF, 8'h02, "kind zero apply done");
		`CHK(driver_pwr, 1'b0, "driver kind zero powers down")
		`CHK(drv_kind, 8'h00, "driver kind applied")
		host.wr(ADDR_KIND, KIND_RST);
		host.wr(ADDR_CMD, CMD_APPLY | 8'h01);
		poll(ADDR_STAT, 8'h80, 8'h80, "restore apply busy");
		poll(ADDR_STAT, 8'hFF, 8'h02, "restore apply done");
		`CHK(driver_pwr, 1'b1, "driver restored")
		`CHK(drv_kind, KIND_RST, "driver kind restored")
		host.wr(ADDR_CMD, CMD_REFRESH);
		poll(ADDR_STAT, 8'h80, 8'h80, "refresh busy");
		poll(ADDR_STAT, 8'hFF, 8'h02, "refresh done");
	endtask : t_kind0
	// direct offset write: pulse on the edge after the one that takes the low byte
	task automatic off_case(input logic [7:0] ctrl, input logic [7:0] sh, input logic [31:0] dat,
		input logic [31:0] e);
		host.wr(ADDR_SHIFT, sh);
		host.wr(ADDR_CTRL, ctrl);
		for (int i = 0; i < 4; i++) host.wr(ADDR_DATA0 + 8'(i), dat[31-8*i -: 8]);
		#1 `CHK(offset_upd, 1'b0, "update too early")
		@(posedge mclk);
		#1 `CHK(offset_upd, ctrl[CTRL_ENA], "update pulse")
		`CHK(freq_offset, e, "offset value")
	endtask : off_case
	task automatic t_offset();
		host.wr(ADDR_LPF_BW, 8'h03);
		host.wr(ADDR_LPF_LIM, 8'h40);
		off_case(8'h44, 8'h00, 32'h00012345, 32'h00012345);
		off_case(8'h64, 8'h00, 32'h00000010, 32'h00012355);
		off_case(8'h64, 8'h00, 32'h00000010, 32'h00012365);
		off_case(8'h40, 8'h00, 32'hFFFFFF00, 32'hFFFFFF00);
		off_case(8'h41, 8'h08, 32'h12345680, 32'hFFFF8000);
		off_case(8'h42, 8'h1F, 32'h77770001, 32'h01000000);
		off_case(8'h44, 8'h00, 32'h7FFFFFFF, 32'sd2144047674);
		off_case(8'h44, 8'h00, 32'h80000000, -32'sd2144047674);
		off_case(8'h04, 8'h00, 32'h00000055, -32'sd2144047674);
		host.wr(ADDR_INC_DIS, 8'h01);
		repeat (2) @(posedge mclk);
		#1 `CHK(addr_autoinc_off, 1'b1, "auto-increment off")
		host.wr(ADDR_SHIFT, 8'h00);
		host.wr(ADDR_CTRL, 8'h52);
		host.wr(ADDR_DATA3, 8'h12);
		host.wr(ADDR_DATA3, 8'h34);
		@(posedge mclk);
		#1 `CHK(offset_upd, 1'b1, "stream update")
		`CHK(freq_offset, 32'h00001234, "stream value")
	endtask : t_offset
	// both reset commands: accepted code, shutdown code, start up, active
	task automatic t_reset();
		logic [7:0] rc [2] = '{CMD_RST_SYS, CMD_RST_POR};
		for (int i = 0; i < 2; i++) begin
			host.wr(ADDR_CMD, rc[i]);
			poll(ADDR_STAT, 8'hFF, 8'h08, "reset accepted");
			poll(ADDR_STAT, 8'hFF, 8'h18, "reset shutting down");
			poll(ADDR_STAT, 8'hFF, 8'h00, "start up");
			poll(ADDR_STAT, 8'h7F, 8'h02, "active after reset");
			`CHK(center_freq, FREQ_RST, "frequency reloaded")
		end
	endtask : t_reset
	initial begin
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		t_boot();
		t_oe();
		t_state();
		t_apply(CMD_APPLY, 32'h4C8F0D18);
		t_apply(CMD_APPLY | 8'h02, 32'h4C9A0000);
		t_apply(CMD_APPLY | 8'h01, 32'h4CA00000);
		t_apply(CMD_APPLY | 8'h03, 32'h4CB00000);
		t_kind0();
		t_offset();
		t_reset();
		wrap_up();
	end
endmodule : oscillator_status_tuning_control_tb

// ### ost_core.sv
// system state, output gating, center frequency apply and offset tuning path
// assumes registers arrive as byte writes and reads from an external serial slave
// What this block does
// - read-only status, zero during start up
// - busy bit spans apply/refresh processing
// - status codes for standby, active, tuning
// - transition codes carry bit 4
// - reset codes: bit 3, then bits 4+3
// - driver powered only when active
// - output enables from stop, run, divider gate
// - standby or zero driver kind powers down
// - apply sets center frequency, offset untouched
// - command byte write is the request moment
// - plain/forced apply hold output off
// - keep-running apply leaves output on
// - offset word is signed 11.21
// - offset clamped to 975 ppm either way
// - offset applied well under 8 us
// - input size 1..4 bytes, 0 means 4
// - left shift 0..24 bits
// - direct mode takes offset word bytes
// - stream mode uses low byte window
// - absolute mode uses input as offset
// - relative mode adds into accumulator
// - multi-byte words stored msb first
`timescale 1ns/1ps
module ost_core #(
	parameter int ACCEPT_LAT = ost_pkg::ACCEPT_CYC,
	parameter logic BOOT_ACTIVE = 1'b1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// byte register port
	input wire ost_pkg::ost_wr_s reg_wr,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	// synthesizer controls
	output logic [31:0] center_freq,
	output logic [7:0] drv_kind,
	output logic driver_pwr,
	output logic clkp_oe,
	output logic clkm_oe,
	output logic addr_autoinc_off,
	// tuning offset
	output logic signed [31:0] freq_offset,
	output logic offset_upd
);
	import ost_pkg::*;

	ost_state_e st_r; // device state
	logic [15:0] st_cnt_r; // cycles left in timed state
	logic [7:0] cmd_r; // pending command, nonzero until accepted
	logic [15:0] lat_r; // acceptance delay
	logic busy_r; // apply/refresh processing
	logic [15:0] proc_r;
	logic hold_r; // output held off while tuning
	logic [31:0] ufreq_r; // user frequency, big endian bytes
	logic [7:0] ukind_r; // user driver kind
	logic [7:0] udrv_r, odiv_r, shift_r, ctrl_r, lpf_bw_r, lpf_lim_r;
	logic [31:0] data_r; // offset input word
	logic [31:0] asm_r; // streamed bytes
	logic [1:0] scnt_r; // streamed byte count
	logic fire_r; // offset input ready
	logic [31:0] raw_r;
	logic signed [31:0] acc_r; // internal offset accumulator
	logic [7:0] stat; // status byte
	logic wr_cmd, acc, start, apply_do, intr, reload, clr, lo_wr;
	logic [1:0] nb; // input bytes minus one
	logic [4:0] sh;
	logic signed [31:0] sx, shv;
	logic signed [32:0] sum, nv;
	logic pwr_nxt;

	// strobes from the register port
	assign wr_cmd = reg_wr.en && reg_wr.addr == ADDR_CMD;
	assign lo_wr = reg_wr.en && reg_wr.addr == ADDR_DATA3;
	assign clr = reg_wr.en && reg_wr.addr == ADDR_CTRL && reg_wr.data[CTRL_CLR];
	// accept once the delay ran out; a fresh write in that cycle wins
	assign acc = cmd_r != 8'h00 && lat_r == 16'h0000 && !wr_cmd;
	assign start = acc && (cmd_r[7:2] == CMD_APPLY[7:2] || cmd_r == CMD_REFRESH) && !busy_r;
	assign apply_do = start && cmd_r[7:2] == CMD_APPLY[7:2] && (cmd_r[0] || ufreq_r != center_freq || ukind_r != drv_kind);
	assign intr = acc && (cmd_r == CMD_READY || cmd_r == CMD_ACTIVE || cmd_r == CMD_RST_SYS || cmd_r == CMD_RST_POR);
	assign reload = st_r == ST_RSTP && st_cnt_r == 16'h0000;

	// command register: request counted from the write of its byte
	always_ff @(posedge mclk) begin
		if (!nrst || reload) begin
			cmd_r <= 8'h00;
			lat_r <= 16'h0000;
		end else if (wr_cmd) begin
			cmd_r <= reg_wr.data;
			lat_r <= 16'(ACCEPT_LAT);
		end else if (acc) begin
			cmd_r <= 8'h00;
		end else if (lat_r != 16'h0000) begin
			lat_r <= lat_r - 16'h0001;
		end
	end

	// device state machine; reset commands interrupt any state, state commands only active/tuning/power-up or standby/power-down
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_r <= ST_BOOT;
			st_cnt_r <= 16'(RST_CYC);
		end else if (acc && (cmd_r == CMD_RST_SYS || cmd_r == CMD_RST_POR)) begin
			st_r <= ST_RSTA;
			st_cnt_r <= 16'(RST_CYC);
		end else if (acc && cmd_r == CMD_READY && (st_r == ST_ACTIVE || st_r == ST_TUNE || st_r == ST_UP)) begin
			st_r <= ST_DOWN;
			st_cnt_r <= 16'(TRANS_CYC);
		end else if (acc && cmd_r == CMD_ACTIVE && (st_r == ST_READY || st_r == ST_DOWN)) begin
			st_r <= ST_UP;
			st_cnt_r <= 16'(TRANS_CYC);
		end else if (apply_do && st_r == ST_ACTIVE) begin
			st_r <= ST_TUNE;
			st_cnt_r <= 16'(TUNE_CYC);
		end else if (st_cnt_r != 16'h0000) begin
			st_cnt_r <= st_cnt_r - 16'h0001;
		end else begin
			case (st_r)
				ST_BOOT: st_r <= BOOT_ACTIVE ? ST_ACTIVE : ST_READY;
				ST_UP, ST_TUNE: st_r <= ST_ACTIVE;
				ST_DOWN: st_r <= ST_READY;
				ST_RSTA: begin
					st_r <= ST_RSTP;
					st_cnt_r <= 16'(RST_CYC);
				end
				ST_RSTP: begin
					st_r <= ST_BOOT;
					st_cnt_r <= 16'(RST_CYC);
				end
				default: st_r <= st_r;
			endcase
		end
	end

	// busy flag; lasts through tuning, new apply/refresh ignored meanwhile
	always_ff @(posedge mclk) begin
		if (!nrst || reload) begin
			busy_r <= 1'b0;
			proc_r <= 16'h0000;
		end else if (start) begin
			busy_r <= 1'b1;
			proc_r <= 16'(PROC_CYC);
		end else if (intr) begin
			busy_r <= 1'b0;
			proc_r <= 16'h0000;
		end else if (proc_r != 16'h0000) begin
			proc_r <= proc_r - 16'h0001;
		end else if (st_r != ST_TUNE) begin
			busy_r <= 1'b0;
		end
	end

	// hold choice taken from the apply variant
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			hold_r <= 1'b0;
		end else if (apply_do) begin
			hold_r <= !cmd_r[1];
		end
	end

	// applied frequency and driver kind; offset path is not touched
	always_ff @(posedge mclk) begin
		if (!nrst || reload) begin
			center_freq <= FREQ_RST;
			drv_kind <= KIND_RST;
		end else if (apply_do) begin
			center_freq <= ufreq_r;
			drv_kind <= ukind_r;
		end
	end

	// user frequency and kind: host writes, refresh copies current back
	always_ff @(posedge mclk) begin
		if (!nrst || reload) begin
			ufreq_r <= FREQ_RST;
			ukind_r <= KIND_RST;
		end else if (start && cmd_r == CMD_REFRESH) begin
			ufreq_r <= center_freq;
			ukind_r <= drv_kind;
		end else if (reg_wr.en && reg_wr.addr >= ADDR_FREQ0 && reg_wr.addr <= ADDR_FREQ3) begin
			// lowest address holds the most significant byte
			ufreq_r[8 * (3 - 32'(reg_wr.addr - ADDR_FREQ0)) +: 8] <= reg_wr.data;
		end else if (reg_wr.en && reg_wr.addr == ADDR_KIND) begin
			ukind_r <= reg_wr.data;
		end
	end

	// plain configuration registers, immediate effect
	always_ff @(posedge mclk) begin
		if (!nrst || reload) begin
			udrv_r <= UDRV_RST;
			odiv_r <= ODIV_RST;
			shift_r <= 8'h00;
			ctrl_r <= 8'h00;
			lpf_bw_r <= 8'h00;
			lpf_lim_r <= 8'h00;
			addr_autoinc_off <= 1'b0;
		end else if (reg_wr.en) begin
			if (reg_wr.addr == ADDR_UDRV) begin
				udrv_r <= reg_wr.data & 8'h03;
			end else if (reg_wr.addr == ADDR_ODIV) begin
				odiv_r <= reg_wr.data & 8'h01;
			end else if (reg_wr.addr == ADDR_SHIFT) begin
				shift_r <= reg_wr.data & 8'h1F;
			end else if (reg_wr.addr == ADDR_CTRL) begin
				ctrl_r <= reg_wr.data & 8'h77; // clear bit is write-one, never stored
			end else if (reg_wr.addr == ADDR_LPF_BW) begin
				lpf_bw_r <= reg_wr.data & 8'h07;
			end else if (reg_wr.addr == ADDR_LPF_LIM) begin
				lpf_lim_r <= reg_wr.data;
			end else if (reg_wr.addr == ADDR_INC_DIS) begin
				addr_autoinc_off <= reg_wr.data[0];
			end
		end
	end

	// driver power and output enables, registered
	assign pwr_nxt = (st_r == ST_ACTIVE || st_r == ST_TUNE) && drv_kind != 8'h00;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			driver_pwr <= 1'b0;
			clkp_oe <= 1'b0;
			clkm_oe <= 1'b0;
		end else begin
			driver_pwr <= pwr_nxt;
			// both outputs share one gate; per-pin disables are not modelled
			clkp_oe <= pwr_nxt && odiv_r[ODIV_OE_ENA] && !udrv_r[UDRV_OE_STOP] && udrv_r[UDRV_RUN]
				&& !(st_r == ST_TUNE && hold_r);
			clkm_oe <= pwr_nxt && odiv_r[ODIV_OE_ENA] && !udrv_r[UDRV_OE_STOP] && udrv_r[UDRV_RUN]
				&& !(st_r == ST_TUNE && hold_r);
		end
	end

	// offset input capture: direct word or streamed low-byte window
	always_ff @(posedge mclk) begin
		if (!nrst || reload) begin
			data_r <= 32'h00000000;
			asm_r <= 32'h00000000;
			scnt_r <= 2'h0;
			fire_r <= 1'b0;
			raw_r <= 32'h00000000;
		end else begin
			fire_r <= 1'b0;
			if (reg_wr.en && reg_wr.addr >= ADDR_DATA0 && reg_wr.addr <= ADDR_DATA3) begin
				data_r[8 * (3 - 32'(reg_wr.addr - ADDR_DATA0)) +: 8] <= reg_wr.data;
			end
			if (reg_wr.en && reg_wr.addr == ADDR_CTRL) begin
				scnt_r <= 2'h0; // restart byte framing on reconfiguration
			end else if (lo_wr && ctrl_r[CTRL_ENA]) begin
				if (!ctrl_r[CTRL_STREAM]) begin
					raw_r <= {data_r[31:8], reg_wr.data};
					fire_r <= 1'b1;
				end else begin
					asm_r <= {asm_r[23:0], reg_wr.data};
					if (scnt_r == nb) begin
						raw_r <= {asm_r[23:0], reg_wr.data};
						fire_r <= 1'b1;
						scnt_r <= 2'h0;
					end else begin
						scnt_r <= scnt_r + 2'h1;
					end
				end
			end
		end
	end

	// size, sign extension, shift and clamp
	always_comb begin
		nb = (ctrl_r[2:0] == 3'h1) ? 2'h0 : (ctrl_r[2:0] == 3'h2) ? 2'h1 : (ctrl_r[2:0] == 3'h3) ? 2'h2 : 2'h3;
		case (nb)
			2'h0: sx = {{24{raw_r[7]}}, raw_r[7:0]};
			2'h1: sx = {{16{raw_r[15]}}, raw_r[15:0]};
			2'h2: sx = {{8{raw_r[23]}}, raw_r[23:0]};
			default: sx = raw_r;
		endcase
		sh = (shift_r[4:0] > SHIFT_MAX) ? SHIFT_MAX : shift_r[4:0];
		shv = sx <<< sh;
		if (ctrl_r[CTRL_REL]) begin
			sum = {acc_r[31], acc_r} + {shv[31], shv};
		end else begin
			sum = {shv[31], shv};
		end
		if (sum > OFFS_LIM) begin
			nv = OFFS_LIM;
		end else if (sum < -OFFS_LIM) begin
			nv = -OFFS_LIM;
		end else begin
			nv = sum;
		end
	end

	// accumulator and applied offset, one cycle after capture
	always_ff @(posedge mclk) begin
		if (!nrst || reload) begin
			acc_r <= 32'sh00000000;
			freq_offset <= 32'sh00000000;
			offset_upd <= 1'b0;
		end else begin
			offset_upd <= fire_r;
			if (fire_r) begin
				acc_r <= nv[31:0];
				freq_offset <= nv[31:0];
			end else if (clr) begin
				acc_r <= 32'sh00000000;
			end
		end
	end

	// status byte from state and busy
	always_comb begin
		stat = 8'h00;
		case (st_r)
			ST_READY: stat[STAT_READY] = 1'b1;
			ST_ACTIVE: stat[STAT_ACTIVE] = 1'b1;
			ST_TUNE: stat = 8'h06;
			ST_UP: stat = 8'h11;
			ST_DOWN: stat = 8'h12;
			ST_RSTA: stat[STAT_RST] = 1'b1;
			ST_RSTP: stat = 8'h18;
			default: stat = 8'h00;
		endcase
		if (st_r != ST_RSTA && st_r != ST_RSTP && st_r != ST_BOOT) begin
			stat[STAT_BUSY] = busy_r;
		end
	end

	// registered read port; unmapped bytes read zero
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rd_data <= 8'h00;
		end else if (rd_addr == ADDR_STAT) begin
			rd_data <= stat;
		end else if (rd_addr == ADDR_CMD) begin
			rd_data <= cmd_r;
		end else if (rd_addr >= ADDR_FREQ0 && rd_addr <= ADDR_FREQ3) begin
			rd_data <= ufreq_r[8 * (3 - 32'(rd_addr - ADDR_FREQ0)) +: 8];
		end else if (rd_addr >= ADDR_DATA0 && rd_addr <= ADDR_DATA3) begin
			rd_data <= data_r[8 * (3 - 32'(rd_addr - ADDR_DATA0)) +: 8];
		end else if (rd_addr == ADDR_KIND) begin
			rd_data <= ukind_r;
		end else if (rd_addr == ADDR_UDRV) begin
			rd_data <= udrv_r;
		end else if (rd_addr == ADDR_ODIV) begin
			rd_data <= odiv_r;
		end else if (rd_addr == ADDR_SHIFT) begin
			rd_data <= shift_r;
		end else if (rd_addr == ADDR_CTRL) begin
			rd_data <= ctrl_r;
		end else if (rd_addr == ADDR_LPF_BW) begin
			rd_data <= lpf_bw_r;
		end else if (rd_addr == ADDR_LPF_LIM) begin
			rd_data <= lpf_lim_r;
		end else if (rd_addr == ADDR_INC_DIS) begin
			rd_data <= {7'h00, addr_autoinc_off};
		end else begin
			rd_data <= 8'h00;
		end
	end

	// checks on the state codes, gating and offset path
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_rst_acc;
		stat == 8'h08;
	endsequence
	sequence s_rst_proc;
		stat == 8'h18;
	endsequence
	sequence s_lo_fire;
		lo_wr && ctrl_r[CTRL_ENA] && !ctrl_r[CTRL_STREAM] && !(reg_wr.en && reg_wr.addr == ADDR_CTRL);
	endsequence
	AST_BOOT_ZERO: assert property (st_r == ST_BOOT && rd_addr == ADDR_STAT |=> rd_data == 8'h00)
		else $error("status not zero at start up");
	AST_BUSY_SET: assert property (start |=> stat[STAT_BUSY] && busy_r)
		else $error("busy not set by apply");
	AST_TUNE_CODE: assert property (apply_do && st_r == ST_ACTIVE |=> stat[6:0] == 7'h06)
		else $error("tuning code wrong");
	AST_UP_CODE: assert property (acc && cmd_r == CMD_ACTIVE && st_r == ST_READY |=> stat[6:0] == 7'h11)
		else $error("ready to active code wrong");
	AST_RST_SEQ: assert property (acc && cmd_r == CMD_RST_SYS |=> s_rst_acc ##[1:100] s_rst_proc)
		else $error("reset status sequence wrong");
	AST_PWR_ACTIVE: assert property (driver_pwr |-> $past(st_r) == ST_ACTIVE || $past(st_r) == ST_TUNE)
		else $error("driver powered outside active");
	AST_OE_GATE: assert property (clkp_oe || clkm_oe |-> driver_pwr && clkp_oe == clkm_oe && $past(odiv_r[ODIV_OE_ENA]))
		else $error("output enabled without gate");
	AST_HOLD_OFF: assert property (st_r == ST_TUNE && hold_r |=> !clkp_oe && !clkm_oe)
		else $error("output on during held tuning");
	AST_KEEP_ON: assert property (st_r == ST_TUNE && !hold_r && clkp_oe && $stable(st_r) |=> clkp_oe || $changed(udrv_r) || $changed(odiv_r) || $changed(st_r))
		else $error("output dropped during keep-running tuning");
	AST_SETTLE: assert property (s_lo_fire |-> ##[1:3] offset_upd)
		else $error("offset not applied in time");
	AST_CLAMP: assert property (offset_upd |-> freq_offset <= OFFS_LIM && freq_offset >= -OFFS_LIM)
		else $error("offset beyond limit");
endmodule : ost_core

// ### ost_host.sv
// register host model driving the byte write strobe and read address
// assumes one clock shared with the block and registered read data
`timescale 1ns/1ps
module ost_host (
	// clock
	input wire logic mclk,
	// byte register port, host side
	output ost_pkg::ost_wr_s reg_wr,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	import ost_pkg::*;
	// idle bus at time zero
	initial begin
		reg_wr = '0;
		rd_addr = 8'h00;
	end
	// one byte write, strobe high for exactly one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= '{en: 1'b1, addr: a, data: d};
		@(posedge mclk);
		// released fields flip so a stale value cannot pass for a live one
		reg_wr <= '{en: 1'b0, addr: ~a, data: ~d};
	endtask : wr
	// read: address at one edge, data registered at the next, sampled once settled
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		rd_addr <= a;
		repeat (2) @(posedge mclk);
		#1 d = rd_data;
	endtask : rd
endmodule : ost_host

// ### ost_pkg.sv
// constants, types and register layout for the oscillator status/tuning block
// assumes a byte-wide register port fed by the serial slave elsewhere in the chip
package ost_pkg;
	// byte register write request
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} ost_wr_s;
	// device states, gray coded along the usual path
	typedef enum logic [2:0] {
		ST_BOOT = 3'h0, ST_READY = 3'h1, ST_UP = 3'h3, ST_ACTIVE = 3'h2,
		ST_TUNE = 3'h6, ST_DOWN = 3'h7, ST_RSTP = 3'h5, ST_RSTA = 3'h4
	} ost_state_e;
	// register byte addresses
	localparam logic [7:0] ADDR_INC_DIS = 8'h06;
	localparam logic [7:0] ADDR_UDRV = 8'h0B;
	localparam logic [7:0] ADDR_FREQ0 = 8'h0E; // msb, freq spans four bytes
	localparam logic [7:0] ADDR_FREQ3 = 8'h11;
	localparam logic [7:0] ADDR_CMD = 8'h12;
	localparam logic [7:0] ADDR_STAT = 8'h13;
	localparam logic [7:0] ADDR_KIND = 8'h14;
	localparam logic [7:0] ADDR_SHIFT = 8'h1B;
	localparam logic [7:0] ADDR_CTRL = 8'h1C;
	localparam logic [7:0] ADDR_DATA0 = 8'h1D; // msb of offset word
	localparam logic [7:0] ADDR_DATA3 = 8'h20; // offset low byte
	localparam logic [7:0] ADDR_ODIV = 8'h3C;
	localparam logic [7:0] ADDR_LPF_BW = 8'h41;
	localparam logic [7:0] ADDR_LPF_LIM = 8'h42;
	// status bits
	localparam int STAT_READY = 0;
	localparam int STAT_ACTIVE = 1;
	localparam int STAT_TUNE = 2;
	localparam int STAT_RST = 3;
	localparam int STAT_TRANS = 4;
	localparam int STAT_BUSY = 7;
	// tuning config fields
	localparam int CTRL_STREAM = 4;
	localparam int CTRL_REL = 5;
	localparam int CTRL_ENA = 6;
	localparam int CTRL_CLR = 7;
	localparam int UDRV_OE_STOP = 0;
	localparam int UDRV_RUN = 1;
	localparam int ODIV_OE_ENA = 0;
	localparam logic [4:0] SHIFT_MAX = 5'h18;
	// commands
	localparam logic [7:0] CMD_READY = 8'h01;
	localparam logic [7:0] CMD_ACTIVE = 8'h02;
	localparam logic [7:0] CMD_RST_SYS = 8'h04;
	localparam logic [7:0] CMD_RST_POR = 8'h05;
	localparam logic [7:0] CMD_APPLY = 8'h08; // bit0 forced, bit1 keep running
	localparam logic [7:0] CMD_REFRESH = 8'h0C;
	// reset values
	localparam logic [7:0] UDRV_RST = 8'h02;
	localparam logic [7:0] ODIV_RST = 8'h01;
	localparam logic [7:0] KIND_RST = 8'h01;
	localparam logic [31:0] FREQ_RST = 32'h4C8583B0;
	// offset scaling: 11.21 word, 2^20 units per 10^6 ppm
	localparam int OFFS_FRAC = 21;
	localparam int PPM_BITS = 20;
	localparam longint OFFS_LIM_PPM = 975;
	localparam logic signed [32:0] OFFS_LIM = 33'((OFFS_LIM_PPM << (OFFS_FRAC + PPM_BITS)) / 64'd1000000);
	// timing, ns figures and cycle counts at 25 ns
	localparam int CLK_NS = 25;
	localparam int ACCEPT_NS = 5000;
	localparam int PROC_NS = 1000;
	localparam int TRANS_NS = 1000;
	localparam int TUNE_NS = 5000;
	localparam int RST_NS = 1000;
	localparam int SETTLE_NS = 8000;
	localparam int ACCEPT_CYC = ACCEPT_NS / CLK_NS - 1;
	localparam int PROC_CYC = PROC_NS / CLK_NS;
	localparam int TRANS_CYC = TRANS_NS / CLK_NS;
	localparam int TUNE_CYC = TUNE_NS / CLK_NS;
	localparam int RST_CYC = RST_NS / CLK_NS;
	localparam int SETTLE_CYC = SETTLE_NS / CLK_NS;
endpackage : ost_pkg
